// ### design/pms_pkg.sv
// Constants shared by the power monitor scaling register block
// Functional notes
// - A written value shows in its register within 4 us of the end of the write transaction.
// - Power and current results reset to zero and current stays zero while the scale factor is zero.
// - Configuration at pointer 00 is read/write, resets to 399F and holds reset, range, gain and ADC settings.
// - Bus voltage is 4 mV per count so the power step is exactly 20 times the current step.
// - Scale factor is trunc(0.04096 / (current step x shunt ohms)) and the device scales current with it.
// - Current result saturates at 32767 counts, and at -32768 for negative results.
// - Pointers 01 and 02 return the latest shunt and bus results and are read-only.
// - Pointer 05 is the writable scale factor setting current and power range, reset 0000.
// - Writing one to configuration bit 15 restores all registers to defaults and the bit clears itself.
`default_nettype none
package pms_pkg;
    // -----------------------------------------------------------------
    // Register map
    // -----------------------------------------------------------------
    localparam int          REG_W         = 16;
    localparam int          PTR_W         = 8;
    localparam logic [7:0]  PTR_CONFIG    = 8'h00;
    localparam logic [7:0]  PTR_SHUNT     = 8'h01;
    localparam logic [7:0]  PTR_BUS       = 8'h02;
    localparam logic [7:0]  PTR_POWER     = 8'h03;
    localparam logic [7:0]  PTR_CURRENT   = 8'h04;
    localparam logic [7:0]  PTR_SCALE     = 8'h05;
    localparam logic [15:0] CONFIG_RESET  = 16'h399F;
    localparam logic [15:0] RESULT_RESET  = 16'h0000;
    localparam logic [15:0] SCALE_RESET   = 16'h0000;
    localparam int          CFG_FULL_RST  = 15;
    // Bus count sits above three status bits
    localparam int          BUS_CNT_LSB   = 3;
    // -----------------------------------------------------------------
    // Arithmetic
    // -----------------------------------------------------------------
    localparam int          SCALE_SHIFT   = 12;
    localparam int          POWER_DIV     = 5000;
    localparam logic [15:0] CUR_POS_MAX   = 16'h7FFF;
    localparam logic [15:0] CUR_NEG_MIN   = 16'h8000;
    localparam logic [15:0] POWER_MAX     = 16'hFFFF;
    // -----------------------------------------------------------------
    // Timing
    // -----------------------------------------------------------------
    localparam int          CLK_PERIOD_NS = 4;
    localparam int          WR_VISIBLE_US = 4;
    localparam int          WR_VISIBLE_CYC = (WR_VISIBLE_US * 1000) / CLK_PERIOD_NS;
endpackage
`default_nettype wire

// ### design/pms_write_stage.sv
// Write capture stage between the serial front end and the register bank
`default_nettype none
module pms_write_stage (
    input  wire logic        i_clk_sys,
    input  wire logic        i_resetn,
    input  wire logic        i_wr,
    input  wire logic [7:0]  i_ptr,
    input  wire logic [15:0] i_wdata,
    output logic             o_apply,
    output logic [7:0]       o_ptr,
    output logic [15:0]      o_data
);
    logic        apply_reg;
    logic        apply_next;
    logic [7:0]  ptr_reg;
    logic [7:0]  ptr_next;
    logic [15:0] data_reg;
    logic [15:0] data_next;

    // -----------------------------------------------------------------
    // Capture
    // -----------------------------------------------------------------
    // One stage keeps the decode off the front-end path; far below 4 us
    always_comb begin
        apply_next = i_wr;
        ptr_next   = i_wr ? i_ptr : ptr_reg;
        data_next  = i_wr ? i_wdata : data_reg;
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_resetn) begin
            apply_reg <= 1'b0;
            ptr_reg   <= 8'h00;
            data_reg  <= 16'h0000;
        end else begin
            apply_reg <= apply_next;
            ptr_reg   <= ptr_next;
            data_reg  <= data_next;
        end
    end

    assign o_apply = apply_reg;
    assign o_ptr   = ptr_reg;
    assign o_data  = data_reg;

    a_wr_forward: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
        i_wr |=> (o_apply && o_ptr == $past(i_ptr) && o_data == $past(i_wdata)))
        else $error("write not forwarded next cycle");
endmodule
`default_nettype wire

// ### design/pms_scale_calc.sv
// Current and power scaling from shunt count, bus count and scale factor
`default_nettype none
module pms_scale_calc (
    input  wire logic        i_clk_sys,
    input  wire logic        i_resetn,
    input  wire logic        i_clear,
    input  wire logic        i_start,
    input  wire logic [15:0] i_shunt,
    input  wire logic [15:0] i_bus,
    input  wire logic [15:0] i_scale,
    output logic [15:0]      o_current,
    output logic [15:0]      o_power,
    output logic             o_done
);
    logic [15:0] cur_reg;
    logic [15:0] cur_next;
    logic [15:0] pow_reg;
    logic [15:0] pow_next;
    logic        stg_reg;
    logic        stg_next;
    logic        done_reg;
    logic        done_next;
    logic [15:0] bus_reg;
    logic [15:0] bus_next;

    // -----------------------------------------------------------------
    // Arithmetic helpers
    // -----------------------------------------------------------------
    function automatic logic [15:0] scale_current(input logic [15:0] sh, input logic [15:0] sc);
        logic signed [33:0] prod;
        logic signed [33:0] q;
        prod = $signed({{18{sh[15]}}, sh}) * $signed({18'h00000, sc});
        q    = prod >>> pms_pkg::SCALE_SHIFT;
        if (q > 34'sd32767)
            return pms_pkg::CUR_POS_MAX;
        else if (q < -34'sd32768)
            return pms_pkg::CUR_NEG_MIN;
        else
            return q[15:0];
    endfunction

    function automatic logic [15:0] scale_power(input logic [15:0] cur, input logic [15:0] bus);
        logic [15:0] mag;
        logic [31:0] prod;
        logic [31:0] q;
        mag  = cur[15] ? 16'(-cur) : cur;
        prod = 32'(mag) * 32'(bus >> pms_pkg::BUS_CNT_LSB);
        q    = prod / 32'(pms_pkg::POWER_DIV);
        return (q > 32'(pms_pkg::POWER_MAX)) ? pms_pkg::POWER_MAX : q[15:0];
    endfunction

    // -----------------------------------------------------------------
    // Two stage pipeline: current, then power from the saturated current
    // -----------------------------------------------------------------
    always_comb begin
        cur_next  = cur_reg;
        pow_next  = pow_reg;
        bus_next  = bus_reg;
        stg_next  = i_start;
        done_next = stg_reg;
        if (i_start) begin
            cur_next = scale_current(i_shunt, i_scale);
            bus_next = i_bus;
        end
        if (stg_reg)
            pow_next = scale_power(cur_reg, bus_reg);
        if (i_clear) begin
            cur_next  = pms_pkg::RESULT_RESET;
            pow_next  = pms_pkg::RESULT_RESET;
            stg_next  = 1'b0;
            done_next = 1'b0;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_resetn) begin
            cur_reg  <= 16'h0000;
            pow_reg  <= 16'h0000;
            bus_reg  <= 16'h0000;
            stg_reg  <= 1'b0;
            done_reg <= 1'b0;
        end else begin
            cur_reg  <= cur_next;
            pow_reg  <= pow_next;
            bus_reg  <= bus_next;
            stg_reg  <= stg_next;
            done_reg <= done_next;
        end
    end

    assign o_current = cur_reg;
    assign o_power   = pow_reg;
    assign o_done    = done_reg;

    a_cur_saturate: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
        (i_start && !i_clear && !i_shunt[15] && i_scale != 16'h0000
         && (34'(i_shunt) * 34'(i_scale)) >= 34'h8000000)
        |=> o_current == 16'h7FFF)
        else $error("current did not saturate at 32767");

    a_power_scale: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
        (stg_reg && !i_clear && !cur_reg[15])
        |=> 32'(o_power) == (32'($past(cur_reg)) * 32'($past(bus_reg) >> 3)) / 32'd5000)
        else $error("power is not current times bus over 5000");
endmodule
`default_nettype wire

// ### design/pms_regs_top.sv
// Register bank of the scaling engine behind the serial pointer port
`default_nettype none
module pms_regs_top (
    input  wire logic        i_clk_sys,
    input  wire logic        i_resetn,
    input  wire logic        i_ptr_load,
    input  wire logic        i_host_wr,
    input  wire logic [7:0]  i_host_ptr,
    input  wire logic [15:0] i_host_wdata,
    input  wire logic        i_meas_valid,
    input  wire logic [15:0] i_shunt_code,
    input  wire logic [15:0] i_bus_code,
    output logic [15:0]      o_host_rdata,
    output logic [15:0]      o_config,
    output logic             o_full_reset,
    output logic             o_results_done
);
    logic [15:0] cfg_reg;
    logic [15:0] cfg_next;
    logic [15:0] scale_reg;
    logic [15:0] scale_next;
    logic [15:0] shunt_reg;
    logic [15:0] shunt_next;
    logic [15:0] bus_reg;
    logic [15:0] bus_next;
    logic [7:0]  ptr_reg;
    logic [7:0]  ptr_next;
    logic [15:0] rdata_reg;
    logic [15:0] rdata_next;
    logic        frst_reg;
    logic        frst_next;
    logic        ap_valid;
    logic [7:0]  ap_ptr;
    logic [15:0] ap_data;
    logic        soft_rst;
    logic [15:0] cur_val;
    logic [15:0] pow_val;
    logic        calc_done;
    logic [15:0] cur_vis;

    // -----------------------------------------------------------------
    // Write stage and scaling pipeline
    // -----------------------------------------------------------------
    pms_write_stage u_wr (
        .i_clk_sys (i_clk_sys),
        .i_resetn  (i_resetn),
        .i_wr      (i_host_wr),
        .i_ptr     (i_host_ptr),
        .i_wdata   (i_host_wdata),
        .o_apply   (ap_valid),
        .o_ptr     (ap_ptr),
        .o_data    (ap_data)
    );

    // Full-reset request decoded straight from the applied write
    assign soft_rst = ap_valid && ap_ptr == pms_pkg::PTR_CONFIG
                      && ap_data[pms_pkg::CFG_FULL_RST];

    pms_scale_calc u_calc (
        .i_clk_sys (i_clk_sys),
        .i_resetn  (i_resetn),
        .i_clear   (soft_rst),
        .i_start   (i_meas_valid && !soft_rst),
        .i_shunt   (i_shunt_code),
        .i_bus     (i_bus_code),
        .i_scale   (scale_reg),
        .o_current (cur_val),
        .o_power   (pow_val),
        .o_done    (calc_done)
    );

    // A zeroed scale factor blanks current even for results already held
    assign cur_vis = (scale_reg == pms_pkg::SCALE_RESET) ? pms_pkg::RESULT_RESET : cur_val;

    // -----------------------------------------------------------------
    // Register bank
    // -----------------------------------------------------------------
    always_comb begin
        cfg_next   = cfg_reg;
        scale_next = scale_reg;
        shunt_next = shunt_reg;
        bus_next   = bus_reg;
        ptr_next   = ptr_reg;
        frst_next  = soft_rst;
        if (i_ptr_load || i_host_wr)
            ptr_next = i_host_ptr;
        if (i_meas_valid) begin
            shunt_next = i_shunt_code;
            bus_next   = i_bus_code;
        end
        if (soft_rst) begin
            cfg_next   = pms_pkg::CONFIG_RESET;
            scale_next = pms_pkg::SCALE_RESET;
            shunt_next = pms_pkg::RESULT_RESET;
            bus_next   = pms_pkg::RESULT_RESET;
        end else if (ap_valid) begin
            if (ap_ptr == pms_pkg::PTR_CONFIG)
                cfg_next = ap_data;
            else if (ap_ptr == pms_pkg::PTR_SCALE)
                scale_next = ap_data;
            // Result and unmapped pointers drop the write
        end
    end

    always_comb begin
        if (ptr_reg == pms_pkg::PTR_CONFIG)
            rdata_next = cfg_reg;
        else if (ptr_reg == pms_pkg::PTR_SHUNT)
            rdata_next = shunt_reg;
        else if (ptr_reg == pms_pkg::PTR_BUS)
            rdata_next = bus_reg;
        else if (ptr_reg == pms_pkg::PTR_POWER)
            rdata_next = pow_val;
        else if (ptr_reg == pms_pkg::PTR_CURRENT)
            rdata_next = cur_vis;
        else if (ptr_reg == pms_pkg::PTR_SCALE)
            rdata_next = scale_reg;
        else
            rdata_next = 16'h0000;
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_resetn) begin
            cfg_reg   <= pms_pkg::CONFIG_RESET;
            scale_reg <= pms_pkg::SCALE_RESET;
            shunt_reg <= pms_pkg::RESULT_RESET;
            bus_reg   <= pms_pkg::RESULT_RESET;
            ptr_reg   <= pms_pkg::PTR_CONFIG;
            rdata_reg <= pms_pkg::RESULT_RESET;
            frst_reg  <= 1'b0;
        end else begin
            cfg_reg   <= cfg_next;
            scale_reg <= scale_next;
            shunt_reg <= shunt_next;
            bus_reg   <= bus_next;
            ptr_reg   <= ptr_next;
            rdata_reg <= rdata_next;
            frst_reg  <= frst_next;
        end
    end

    assign o_host_rdata   = rdata_reg;
    assign o_config       = cfg_reg;
    assign o_full_reset   = frst_reg;
    assign o_results_done = calc_done;

    // -----------------------------------------------------------------
    // Checks
    // -----------------------------------------------------------------
    localparam int WR_MAX = pms_pkg::WR_VISIBLE_CYC;

    a_wr_visible: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
        (i_host_wr && i_host_ptr == 8'h05 && !i_ptr_load)
        |-> ##[1:WR_MAX] scale_reg == $past(i_host_wdata, 2))
        else $error("scale write not visible in time");

    a_cfg_write: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
        (ap_valid && ap_ptr == 8'h00 && !ap_data[15]) |=> cfg_reg == $past(ap_data))
        else $error("configuration write lost");

    a_cfg_por: assert property (@(posedge i_clk_sys)
        !i_resetn |=> (cfg_reg == 16'h399F && scale_reg == 16'h0000 && o_host_rdata == 16'h0000))
        else $error("reset values wrong");

    a_full_reset: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
        soft_rst |=> (cfg_reg == 16'h399F && !cfg_reg[15] && scale_reg == 16'h0000 && o_full_reset))
        else $error("full reset did not restore defaults");

    a_cur_zero_cal: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
        (scale_reg == 16'h0000 && ptr_reg == 8'h04) |=> o_host_rdata == 16'h0000)
        else $error("current nonzero with zero scale factor");

    a_result_ro: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
        (ap_valid && (ap_ptr == 8'h01 || ap_ptr == 8'h02) && !i_meas_valid)
        |=> (shunt_reg == $past(shunt_reg) && bus_reg == $past(bus_reg)))
        else $error("result register took a host write");

    a_unmapped_zero: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
        (ptr_reg > 8'h05) |=> o_host_rdata == 16'h0000)
        else $error("unmapped pointer read nonzero");

    a_unmapped_wr: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
        (ap_valid && ap_ptr > 8'h05) |=> (cfg_reg == $past(cfg_reg) && scale_reg == $past(scale_reg)))
        else $error("unmapped write disturbed a register");

    a_scale_write: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
        (ap_valid && ap_ptr == 8'h05) |=> scale_reg == $past(ap_data))
        else $error("scale factor write lost");
endmodule
`default_nettype wire

// ### sim/pms_host_model.sv
// Serial host model driving the pointer port of the scaling registers
`default_nettype none
module pms_host_model (
    input  wire logic        i_clk_sys,
    input  wire logic [15:0] i_rdata,
    output logic             o_ptr_load,
    output logic             o_wr,
    output logic [7:0]       o_ptr,
    output logic [15:0]      o_wdata
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        o_ptr_load = 1'b0;
        o_wr       = 1'b0;
        o_ptr      = 8'h00;
        o_wdata    = 16'h0000;
    end
    // -----------------------------------------------------------------
    // Transactions
    // -----------------------------------------------------------------
    // Released lines flip so a stale value can never look valid
    task automatic release_bus();
        o_ptr   = ~o_ptr;
        o_wdata = ~o_wdata;
    endtask
    task automatic write(input logic [7:0] ptr, input logic [15:0] data);
        @(negedge i_clk_sys);
        o_wr    = 1'b1;
        o_ptr   = ptr;
        o_wdata = data;
        @(negedge i_clk_sys);
        o_wr = 1'b0;
        release_bus();
    endtask
    // Always reloads the pointer, so no post-write wait is owed
    task automatic read(input logic [7:0] ptr, output logic [15:0] data);
        @(negedge i_clk_sys);
        o_ptr_load = 1'b1;
        o_ptr      = ptr;
        @(negedge i_clk_sys);
        o_ptr_load = 1'b0;
        release_bus();
        @(negedge i_clk_sys);
        data = i_rdata;
    endtask
    // -----------------------------------------------------------------
    // Calibration arithmetic
    // -----------------------------------------------------------------
    // Step in uA and shunt in milliohm; step chosen in max/32767..max/4096
    function automatic logic [15:0] cal_value(input int lsb_ua, input int r_mohm);
        return 16'(40960000 / (lsb_ua * r_mohm));
    endfunction
    function automatic logic [15:0] trim(input logic [15:0] cal, input int meas, input int rep);
        return 16'(int'(cal) * meas / rep);
    endfunction
endmodule
`default_nettype wire

// ### sim/pms_regs_top_tb.sv
// Self-checking bench for the scaling register bank
`default_nettype none
module pms_regs_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk;
    logic        resetn;
    logic        ptr_load;
    logic        wr;
    logic [7:0]  ptr;
    logic [15:0] wdata;
    logic        meas_valid;
    logic [15:0] shunt;
    logic [15:0] bus;
    logic [15:0] rdata;
    logic [15:0] config_q;
    logic        full_reset;
    logic        done;
    int          fails;
    int          checked;
    int          cycles;
    int          rst_pulses;
    logic [15:0] last_sh;
    logic [15:0] last_bu;
    logic [15:0] sh_tab [5] = '{16'h0FA0, 16'hF060, 16'h7D00, 16'h8300, 16'h0100};
    logic [15:0] sc_tab [5];

    pms_regs_top pms_regs_top_i (
        .i_clk_sys      (clk),
        .i_resetn       (resetn),
        .i_ptr_load     (ptr_load),
        .i_host_wr      (wr),
        .i_host_ptr     (ptr),
        .i_host_wdata   (wdata),
        .i_meas_valid   (meas_valid),
        .i_shunt_code   (shunt),
        .i_bus_code     (bus),
        .o_host_rdata   (rdata),
        .o_config       (config_q),
        .o_full_reset   (full_reset),
        .o_results_done (done)
    );
    pms_host_model pms_host_model_i (
        .i_clk_sys  (clk),
        .i_rdata    (rdata),
        .o_ptr_load (ptr_load),
        .o_wr       (wr),
        .o_ptr      (ptr),
        .o_wdata    (wdata)
    );
    // -----------------------------------------------------------------
    // Clock, watchdog and helpers
    // -----------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // Off-edge sampling so a one-cycle pulse is counted exactly once
    always @(negedge clk) begin
        cycles++;
        if (full_reset === 1'b1) rst_pulses++;
        if (cycles == 20000) begin
            fails++;
            complete_run();
        end
    end
    task automatic complete_run();
        if (fails == 0 && checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic rd_chk(input logic [7:0] p, input logic [15:0] exp);
        logic [15:0] d;
        pms_host_model_i.read(p, d);
        chk($sformatf("register %h", p), exp, d);
    endtask
    // Floor shift of the signed product, clamped to 16-bit signed
    function automatic logic [15:0] exp_cur(input logic [15:0] sh, input logic [15:0] sc);
        longint p;
        p = (longint'($signed(sh)) * longint'(sc)) >>> 12;
        if (p > 32767) return 16'h7FFF;
        if (p < -32768) return 16'h8000;
        return p[15:0];
    endfunction
    function automatic logic [15:0] exp_pow(input logic [15:0] c, input logic [15:0] b);
        longint m;
        m = longint'($signed(c));
        if (m < 0) m = -m;
        m = m * longint'(b >> 3) / 5000;
        return (m > 65535) ? 16'hFFFF : m[15:0];
    endfunction
    task automatic measure(input logic [15:0] sh, input logic [15:0] bu, input logic [15:0] sc);
        logic [15:0] c;
        c = exp_cur(sh, sc);
        @(negedge clk);
        meas_valid = 1'b1;
        shunt      = sh;
        bus        = bu;
        @(negedge clk);
        meas_valid = 1'b0;
        shunt      = ~sh;
        bus        = ~bu;
        last_sh    = sh;
        last_bu    = bu;
        chk("early done", 16'h0000, {15'h0000, done});
        @(negedge clk);
        chk("done", 16'h0001, {15'h0000, done});
        rd_chk(pms_pkg::PTR_SHUNT, sh);
        rd_chk(pms_pkg::PTR_BUS, bu);
        rd_chk(pms_pkg::PTR_CURRENT, c);
        rd_chk(pms_pkg::PTR_POWER, exp_pow(c, bu));
    endtask
    task automatic check_defaults();
        for (int p = 0; p < 7; p++) begin
            rd_chk(8'(p), (p == 0) ? 16'h399F : 16'h0000);
        end
        rd_chk(8'hFF, 16'h0000);
        chk("config port", 16'h399F, config_q);
    endtask
    // -----------------------------------------------------------------
    // Scenarios
    // -----------------------------------------------------------------
    task automatic t_scale_zero();
        measure(16'h1388, 16'h5DC0, 16'h0000);
    endtask
    // Read back without pointer reload only after the full settle time
    task automatic t_calibrate();
        sc_tab = '{pms_host_model_i.cal_value(20, 500), 16'd21557, 16'd21557, 16'd21557,
                   pms_host_model_i.trim(16'd21557, 25090, 25247)};
        for (int i = 0; i < 5; i++) begin
            pms_host_model_i.write(pms_pkg::PTR_SCALE, sc_tab[i]);
            repeat (pms_pkg::WR_VISIBLE_CYC) @(negedge clk);
            chk("scale visible", sc_tab[i], rdata);
            measure(sh_tab[i], 16'h5DC0, sc_tab[i]);
        end
    endtask
    task automatic t_read_only();
        for (int p = 1; p < 5; p++) begin
            pms_host_model_i.write(8'(p), 16'hA5A5);
        end
        pms_host_model_i.write(8'h06, 16'h5A5A);
        pms_host_model_i.write(8'hFF, 16'h5A5A);
        rd_chk(pms_pkg::PTR_SHUNT, last_sh);
        rd_chk(pms_pkg::PTR_BUS, last_bu);
        rd_chk(pms_pkg::PTR_CURRENT, exp_cur(last_sh, sc_tab[4]));
        rd_chk(pms_pkg::PTR_SCALE, sc_tab[4]);
        rd_chk(8'h06, 16'h0000);
        rd_chk(pms_pkg::PTR_CONFIG, 16'h399F);
    endtask
    task automatic t_config();
        pms_host_model_i.write(pms_pkg::PTR_CONFIG, 16'h1234);
        rd_chk(pms_pkg::PTR_CONFIG, 16'h1234);
        chk("config port", 16'h1234, config_q);
    endtask
    task automatic t_full_reset();
        rst_pulses = 0;
        pms_host_model_i.write(pms_pkg::PTR_CONFIG, 16'hB123);
        repeat (5) @(negedge clk);
        chk("reset pulses", 16'h0001, 16'(rst_pulses));
        check_defaults();
    endtask
    // -----------------------------------------------------------------
    // Main sequence
    // -----------------------------------------------------------------
    initial begin
        resetn     = 1'b0;
        meas_valid = 1'b0;
        shunt      = 16'h0000;
        bus        = 16'h0000;
        repeat (10) @(negedge clk);
        resetn = 1'b1;
        check_defaults();
        t_scale_zero();
        t_calibrate();
        t_read_only();
        t_config();
        t_full_reset();
        complete_run();
    end
endmodule
`default_nettype wire
